// ===== inc/dtmg_defines.svh
// Constants for the dual-tone melody generator: map, fields, tables
`ifndef DTMG_DEFINES_SVH
`define DTMG_DEFINES_SVH

// ----------------------------------------------------------------------
// Register indices and byte addresses (byte address = index * 4)
// ----------------------------------------------------------------------
`define DTMG_IDX_ROW_SEL 10'h00d
`define DTMG_IDX_COL_SEL 10'h00e
`define DTMG_IDX_TONE_CTRL 10'h00f
`define DTMG_IDX_POWER 10'h010
`define DTMG_ADDR_ROW_SEL {`DTMG_IDX_ROW_SEL, 2'b00}
`define DTMG_ADDR_COL_SEL {`DTMG_IDX_COL_SEL, 2'b00}
`define DTMG_ADDR_TONE_CTRL {`DTMG_IDX_TONE_CTRL, 2'b00}
`define DTMG_ADDR_POWER {`DTMG_IDX_POWER, 2'b00}

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define DTMG_TC_MODE_HI 7
`define DTMG_TC_MODE_LO 6
`define DTMG_TC_ROW_EN 5
`define DTMG_TC_COL_EN 4
`define DTMG_TC_OUT_EN 3
`define DTMG_PW_WAIT 0
`define DTMG_PW_STOP 1
`define DTMG_PW_ROW_ACT 4
`define DTMG_PW_COL_ACT 5
`define DTMG_PW_ILLEGAL 6
`define DTMG_SEL_RESET 5'h00
`define DTMG_TC_RESET 8'h00

// ----------------------------------------------------------------------
// Tone codes, scanner and levels
// ----------------------------------------------------------------------
`define DTMG_ROW_DTMF_MAX 5'h03
`define DTMG_COL_DTMF_MIN 5'h10
`define DTMG_COL_DTMF_MAX 5'h13
`define DTMG_SCAN_LAST 5'h1b
`define DTMG_LEVEL_MID 6'h20

// Divisor per tone code in 100 MHz cycles per step, code 31 first
`define DTMG_DIV_TABLE { \
    13'h05e5, 13'h0654, 13'h06c4, 13'h06fc, 13'h076c, 13'h07db, \
    13'h084b, 13'h08f3, 13'h0963, 13'h0a0a, 13'h0a7a, 13'h0b22, \
    13'h0883, 13'h0963, 13'h0a7a, 13'h0b91, \
    13'h0bc9, 13'h0ca9, 13'h0d50, 13'h0e30, 13'h0f0f, 13'h0fef, \
    13'h10ce, 13'h11e6, 13'h12c5, 13'h1414, 13'h152b, 13'h167b, \
    13'h0ed7, 13'h1055, 13'h121e, 13'h1414}

// Staircase sine, 28 entries of 6 bits, entry 27 first
`define DTMG_SINE_TABLE { \
    6'h19, 6'h13, 6'h0d, 6'h08, 6'h04, 6'h02, 6'h01, \
    6'h02, 6'h04, 6'h08, 6'h0d, 6'h13, 6'h19, 6'h1f, \
    6'h27, 6'h2d, 6'h33, 6'h38, 6'h3c, 6'h3e, 6'h3f, \
    6'h3e, 6'h3c, 6'h38, 6'h33, 6'h2d, 6'h27, 6'h20}

`endif

// ===== inc/dtmg_pkg.sv
// Types shared by the dual-tone melody generator
package dtmg_pkg;
    typedef enum logic [1:0] {DTMG_SINE, DTMG_SQ1, DTMG_SQ2, DTMG_SQ3}
        dtmg_mode_e;
    typedef logic [4:0] dtmg_code_t;
    typedef logic [12:0] dtmg_div_t;
    typedef logic [5:0] dtmg_level_t;
endpackage

// ===== inc/dtmg_path_if.sv
// Signals between the controller and one tone path
`timescale 1ns/1ps
interface dtmg_path_if;
    import dtmg_pkg::*;
    logic run;
    logic hold;
    dtmg_div_t divisor;
    dtmg_level_t sample;
    logic msb;
    modport ctrl (output run, output hold, output divisor,
        input sample, input msb);
    modport path (input run, input hold, input divisor,
        output sample, output msb);
endinterface

// ===== hw/dtmg_divisor_lut.sv
// Tone code to divisor lookup and per-path legality check
`timescale 1ns/1ps
`include "dtmg_defines.svh"
module dtmg_divisor_lut #(
    parameter bit COLUMN_PATH = 1'b0
) (
    input wire dtmg_pkg::dtmg_code_t code,
    output wire dtmg_pkg::dtmg_div_t divisor,
    output wire logic legal
);
    import dtmg_pkg::*;

    localparam logic [32*13-1:0] DIV_TABLE = `DTMG_DIV_TABLE;

    // Other group's dialling codes are refused on this path
    wire logic rowDtmf = code <= `DTMG_ROW_DTMF_MAX;
    wire logic colDtmf = code >= `DTMG_COL_DTMF_MIN &&
        code <= `DTMG_COL_DTMF_MAX;
    assign legal = COLUMN_PATH ? !rowDtmf : !colDtmf;

    // Melody codes share one divisor on either path
    assign divisor = DIV_TABLE[code*13 +: 13];
endmodule

// ===== hw/dtmg_tone_path.sv
// One tone path: step divider, 28-step scanner and sine lookup
`timescale 1ns/1ps
`include "dtmg_defines.svh"
module dtmg_tone_path (
    input wire logic clk,
    input wire logic rst,
    dtmg_path_if.path pathIf
);
    import dtmg_pkg::*;

    localparam logic [28*6-1:0] SINE_TABLE = `DTMG_SINE_TABLE;

    dtmg_div_t divCnt_reg;
    dtmg_div_t divCnt_next;
    logic [4:0] scan_reg;
    logic [4:0] scan_next;

    // ------------------------------------------------------------------
    // Counter next values
    // ------------------------------------------------------------------
    wire logic stepTick = divCnt_reg >= pathIf.divisor - 13'h0001;
    wire logic scanWrap = scan_reg == `DTMG_SCAN_LAST;

    // Inactive path sits at step zero; hold freezes everything
    assign divCnt_next = !pathIf.run ? 13'h0000 :
        pathIf.hold ? divCnt_reg :
        stepTick ? 13'h0000 : divCnt_reg + 13'h0001;
    assign scan_next = !pathIf.run ? 5'h00 :
        (pathIf.hold || !stepTick) ? scan_reg :
        scanWrap ? 5'h00 : scan_reg + 5'h01;

    // Divider and scanner registers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            divCnt_reg <= 13'h0000;
            scan_reg <= 5'h00;
        end
        else
        begin
            divCnt_reg <= divCnt_next;
            scan_reg <= scan_next;
        end
    end

    // Entry zero holds the midpoint value
    assign pathIf.sample = SINE_TABLE[scan_reg*6 +: 6];
    assign pathIf.msb = pathIf.sample[5];

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_scan_wrap;
        @(posedge clk) disable iff (rst)
        pathIf.run && !pathIf.hold && stepTick && scanWrap |=>
            scan_reg == 5'h00;
    endproperty
    a_scan_wrap: assert property (p_scan_wrap)
        else $error("scanner did not wrap after step 27");

    property p_scan_range;
        @(posedge clk) disable iff (rst)
        scan_reg <= `DTMG_SCAN_LAST;
    endproperty
    a_scan_range: assert property (p_scan_range)
        else $error("scanner beyond 28 steps");
endmodule

// ===== hw/dtmg_top.sv
// Dual-tone melody generator with APB control registers
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "dtmg_defines.svh"

module dtmg_top (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output dtmg_pkg::dtmg_level_t mixedToneRowLevel,
    output dtmg_pkg::dtmg_level_t mixedToneColumnLevel,
    output logic mixedTonePinOe,
    output logic pacifierPin
);
    import dtmg_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    dtmg_code_t rowToneSelect_reg;
    dtmg_code_t columnToneSelect_reg;
    dtmg_mode_e waveformMode_reg;
    logic rowPathEnable_reg;
    logic columnPathEnable_reg;
    logic mixedOutputEnable_reg;
    logic waitReq_reg;
    logic stopReq_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    dtmg_level_t rowLevel_reg;
    dtmg_level_t columnLevel_reg;
    logic mixedTonePinOe_reg;
    logic pacifierPin_reg;
    dtmg_div_t rowDivisor;
    dtmg_div_t columnDivisor;
    logic rowLegal;
    logic columnLegal;

    dtmg_path_if rowIf ();
    dtmg_path_if columnIf ();

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    wire logic setupPhase = psel && !penable;
    wire logic accessDone = psel && penable && pready_reg;
    wire logic hitRow = paddr == `DTMG_ADDR_ROW_SEL;
    wire logic hitColumn = paddr == `DTMG_ADDR_COL_SEL;
    wire logic hitCtrl = paddr == `DTMG_ADDR_TONE_CTRL;
    wire logic hitPower = paddr == `DTMG_ADDR_POWER;
    wire logic unmapped = !(hitRow || hitColumn || hitCtrl || hitPower);
    wire logic wrRow = accessDone && pwrite && hitRow;
    wire logic wrColumn = accessDone && pwrite && hitColumn;
    wire logic wrCtrl = accessDone && pwrite && hitCtrl;
    wire logic wrPower = accessDone && pwrite && hitPower;

    // ------------------------------------------------------------------
    // Legality and path control
    // ------------------------------------------------------------------
    dtmg_divisor_lut #(
        .COLUMN_PATH(1'b0)
    ) u_row_lut (
        .code(rowToneSelect_reg),
        .divisor(rowDivisor),
        .legal(rowLegal)
    );

    dtmg_divisor_lut #(
        .COLUMN_PATH(1'b1)
    ) u_column_lut (
        .code(columnToneSelect_reg),
        .divisor(columnDivisor),
        .legal(columnLegal)
    );

    // Checked every cycle on the current selects
    wire logic illegalCode = !rowLegal || !columnLegal;
    wire logic rowRun = rowPathEnable_reg && !illegalCode;
    wire logic columnRun = columnPathEnable_reg && !illegalCode;
    wire logic squareMode = waveformMode_reg != DTMG_SINE;
    wire logic pacifierMode = waveformMode_reg == DTMG_SQ2 ||
        waveformMode_reg == DTMG_SQ3;

    // Path hookup; stop freezes both paths, wait does not
    assign rowIf.run = rowRun;
    assign rowIf.hold = stopReq_reg;
    assign rowIf.divisor = rowDivisor;
    assign columnIf.run = columnRun;
    assign columnIf.hold = stopReq_reg;
    assign columnIf.divisor = columnDivisor;

    dtmg_tone_path u_row_path (
        .clk(clk),
        .rst(rst),
        .pathIf(rowIf.path)
    );

    dtmg_tone_path u_column_path (
        .clk(clk),
        .rst(rst),
        .pathIf(columnIf.path)
    );

    // ------------------------------------------------------------------
    // Output shaping
    // ------------------------------------------------------------------
    // Square modes keep only the top bit of each entry
    wire dtmg_level_t rowShaped = squareMode ?
        {rowIf.msb, 5'h00} : rowIf.sample;
    wire dtmg_level_t columnShaped = squareMode ?
        {columnIf.msb, 5'h00} : columnIf.sample;
    wire logic rowToMix = rowRun && mixedOutputEnable_reg &&
        !stopReq_reg && waveformMode_reg != DTMG_SQ3;
    wire logic columnToMix = columnRun && mixedOutputEnable_reg &&
        !stopReq_reg;
    wire dtmg_level_t rowLevel_next = rowToMix ?
        rowShaped : `DTMG_LEVEL_MID;
    wire dtmg_level_t columnLevel_next = columnToMix ?
        columnShaped : `DTMG_LEVEL_MID;
    wire logic mixedTonePinOe_next = mixedOutputEnable_reg &&
        !stopReq_reg;
    wire logic pacifierPin_next = (pacifierMode && rowRun &&
        !stopReq_reg) ? rowIf.msb : 1'b1;

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    wire logic [31:0] rdRow = {27'h0, rowToneSelect_reg};
    wire logic [31:0] rdColumn = {27'h0, columnToneSelect_reg};
    wire logic [31:0] rdCtrl = {24'h000000, waveformMode_reg,
        rowPathEnable_reg, columnPathEnable_reg,
        mixedOutputEnable_reg, 3'h0};
    wire logic [31:0] rdPower = {25'h0, illegalCode, columnRun,
        rowRun, 2'h0, stopReq_reg, waitReq_reg};
    wire logic [31:0] rdMux = hitRow ? rdRow :
        hitColumn ? rdColumn :
        hitCtrl ? rdCtrl :
        hitPower ? rdPower : 32'h00000000;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // APB answer: ready in the access cycle after setup
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            prdata_reg <= 32'h00000000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end
        else
        begin
            prdata_reg <= setupPhase ? rdMux : prdata_reg;
            pready_reg <= setupPhase;
            pslverr_reg <= setupPhase && unmapped;
        end
    end

    // Tone selects
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rowToneSelect_reg <= `DTMG_SEL_RESET;
            columnToneSelect_reg <= `DTMG_SEL_RESET;
        end
        else
        begin
            if (wrRow)
                rowToneSelect_reg <= pwdata[4:0];
            if (wrColumn)
                columnToneSelect_reg <= pwdata[4:0];
        end
    end

    // Tone control; both enables land from one write word
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            waveformMode_reg <= dtmg_mode_e'(`DTMG_TC_RESET >> 6);
            rowPathEnable_reg <= 1'b0;
            columnPathEnable_reg <= 1'b0;
            mixedOutputEnable_reg <= 1'b0;
        end
        else if (wrCtrl)
        begin
            waveformMode_reg <= dtmg_mode_e'(pwdata[7:6]);
            rowPathEnable_reg <= pwdata[`DTMG_TC_ROW_EN];
            columnPathEnable_reg <= pwdata[`DTMG_TC_COL_EN];
            mixedOutputEnable_reg <= pwdata[`DTMG_TC_OUT_EN];
        end
    end

    // Low-power requests
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            waitReq_reg <= 1'b0;
            stopReq_reg <= 1'b0;
        end
        else if (wrPower)
        begin
            waitReq_reg <= pwdata[`DTMG_PW_WAIT];
            stopReq_reg <= pwdata[`DTMG_PW_STOP];
        end
    end

    // Pin registers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rowLevel_reg <= `DTMG_LEVEL_MID;
            columnLevel_reg <= `DTMG_LEVEL_MID;
            mixedTonePinOe_reg <= 1'b0;
            pacifierPin_reg <= 1'b1;
        end
        else
        begin
            rowLevel_reg <= rowLevel_next;
            columnLevel_reg <= columnLevel_next;
            mixedTonePinOe_reg <= mixedTonePinOe_next;
            pacifierPin_reg <= pacifierPin_next;
        end
    end

    // Outputs straight from flip-flops
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign mixedToneRowLevel = rowLevel_reg;
    assign mixedToneColumnLevel = columnLevel_reg;
    assign mixedTonePinOe = mixedTonePinOe_reg;
    assign pacifierPin = pacifierPin_reg;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_illegal_mute;
        @(posedge clk) disable iff (rst)
        illegalCode |=> pacifierPin_reg &&
            rowLevel_reg == `DTMG_LEVEL_MID &&
            columnLevel_reg == `DTMG_LEVEL_MID;
    endproperty
    a_illegal_mute: assert property (p_illegal_mute)
        else $error("tone not muted on illegal code");

    property p_cross_code;
        @(posedge clk) disable iff (rst)
        rowToneSelect_reg inside {[5'h10:5'h13]} ||
            columnToneSelect_reg <= 5'h03 |-> !rowRun && !columnRun;
    endproperty
    a_cross_code: assert property (p_cross_code)
        else $error("cross-group code not refused");

    property p_pacifier_high;
        @(posedge clk) disable iff (rst)
        !pacifierMode |=> pacifierPin_reg;
    endproperty
    a_pacifier_high: assert property (p_pacifier_high)
        else $error("pacifier not high in modes 00 and 01");

    property p_pacifier_row;
        @(posedge clk) disable iff (rst)
        pacifierMode && rowRun && !stopReq_reg |=>
            pacifierPin_reg == $past(rowIf.msb);
    endproperty
    a_pacifier_row: assert property (p_pacifier_row)
        else $error("pacifier does not follow row top bit");

    property p_sq3_no_row;
        @(posedge clk) disable iff (rst)
        waveformMode_reg == DTMG_SQ3 |=>
            rowLevel_reg == `DTMG_LEVEL_MID;
    endproperty
    a_sq3_no_row: assert property (p_sq3_no_row)
        else $error("row tone present in mode 11");

    property p_both_off;
        @(posedge clk) disable iff (rst)
        !rowPathEnable_reg && !columnPathEnable_reg |=>
            rowIf.sample == `DTMG_LEVEL_MID &&
            columnIf.sample == `DTMG_LEVEL_MID;
    endproperty
    a_both_off: assert property (p_both_off)
        else $error("paths not reset with both enables low");

    property p_start_mid;
        @(posedge clk) disable iff (rst)
        $rose(rowRun) |-> rowIf.sample == `DTMG_LEVEL_MID;
    endproperty
    a_start_mid: assert property (p_start_mid)
        else $error("row path did not start from reset");

    property p_out_enable;
        @(posedge clk) disable iff (rst)
        !mixedOutputEnable_reg |=> !mixedTonePinOe_reg &&
            rowLevel_reg == `DTMG_LEVEL_MID;
    endproperty
    a_out_enable: assert property (p_out_enable)
        else $error("mixed output active without enable");

    property p_square_mask;
        @(posedge clk) disable iff (rst)
        squareMode |=> rowLevel_reg[4:0] == 5'h00 &&
            columnLevel_reg[4:0] == 5'h00;
    endproperty
    a_square_mask: assert property (p_square_mask)
        else $error("low bits not masked in square mode");

    property p_stop_idle;
        @(posedge clk) disable iff (rst)
        stopReq_reg |=> pacifierPin_reg && !mixedTonePinOe_reg;
    endproperty
    a_stop_idle: assert property (p_stop_idle)
        else $error("pins not idle in stop");
endmodule

// ===== tb/dtmg_analog_model.sv
// Behavioural ladder and summing stage facing the tone outputs
`timescale 1ns/1ps
module dtmg_analog_model (
    input wire dtmg_pkg::dtmg_level_t rowLevel,
    input wire dtmg_pkg::dtmg_level_t columnLevel,
    input wire logic outEnable,
    output logic [6:0] mixSum,
    output logic mixDriven
);
    import dtmg_pkg::*;
    // Sum of both ladder codes; 0x40 is the mid-supply idle level
    assign mixSum = outEnable ? rowLevel + columnLevel : 7'h00;
    // Pin floats unless the output enable is set
    assign mixDriven = outEnable;
endmodule

// ===== tb/dual_tone_melody_generator_tb_top.sv
// Testbench: APB stimulus, tone output and code legality checks
`timescale 1ns/1ps
`include "dtmg_defines.svh"
module dual_tone_melody_generator_tb_top;
    import dtmg_pkg::*;
    localparam logic [11:0] AR = `DTMG_ADDR_ROW_SEL;
    localparam logic [11:0] AC = `DTMG_ADDR_COL_SEL;
    localparam logic [11:0] AT = `DTMG_ADDR_TONE_CTRL;
    localparam logic [11:0] AP = `DTMG_ADDR_POWER;
    localparam int D_R0 = 5140;
    localparam int D_C10 = 2961;
    localparam int D_1F = 1509;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    dtmg_level_t rowLvl;
    dtmg_level_t colLvl;
    logic pinOe;
    logic pacPin;
    logic [6:0] mixSum;
    logic mixDriven;
    logic [31:0] rd;
    logic err;
    logic [7:0] lfsr = 8'h18;
    int fails = 0;
    int nChecks = 0;

    // ------------------------------------------------------------
    // Clock, design and far-side model
    // ------------------------------------------------------------
    always #5 clk = ~clk;
    dtmg_top i_dut (.clk(clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mixedToneRowLevel(rowLvl),
        .mixedToneColumnLevel(colLvl), .mixedTonePinOe(pinOe),
        .pacifierPin(pacPin));
    dtmg_analog_model i_far (.rowLevel(rowLvl), .columnLevel(colLvl),
        .outEnable(pinOe), .mixSum(mixSum), .mixDriven(mixDriven));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] lfsrNext(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // Other group's dialling code in a select mutes everything
    function automatic logic illegal(input logic [4:0] r,
        input logic [4:0] c);
        return (r >= 5'h10 && r <= 5'h13) || c <= 5'h03;
    endfunction
    task automatic test_done();
        if (fails == 0 && nChecks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nChecks++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic lv(input dtmg_level_t r, input dtmg_level_t c);
        chk({26'h0, rowLvl}, {26'h0, r});
        chk({26'h0, colLvl}, {26'h0, c});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        chk(n < 20, 1);
        if (n >= 20)
            test_done();
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        int i;
        logic [4:0] r;
        logic [4:0] c;
        logic ill;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        cyc(1);
        lv(6'h20, 6'h20);
        chk({pinOe, pacPin, mixDriven}, 3'b010);
        apb(0, AT, 0);
        chk(rd, 0);
        apb(0, 12'h100, 0);
        chk(rd, 0);
        chk(err, 1);
        // Random and corner selects with both paths enabled
        apb(1, AT, 32'h30);
        for (i = 0; i < 14; i++)
        begin
            lfsr = lfsrNext(lfsr);
            r = (i == 0) ? 5'h03 : (i == 1) ? 5'h13 : lfsr[4:0];
            lfsr = lfsrNext(lfsr);
            c = (i == 0) ? 5'h03 : (i == 1) ? 5'h1f : lfsr[4:0];
            ill = illegal(r, c);
            apb(1, AR, {lfsr, 19'h0, r});
            apb(1, AC, {24'h0, 3'h7, c});
            apb(0, AR, 0);
            chk(rd, {27'h0, r});
            apb(0, AP, 0);
            chk(rd, {25'h0, ill, ~ill, ~ill, 4'h0});
        end
        // Row path only, then off, then column path only
        apb(1, AT, 0);
        apb(1, AR, 0);
        apb(1, AC, 32'h10);
        apb(1, AT, 32'h28);
        cyc(D_R0 - 10);
        lv(6'h20, 6'h20);
        cyc(20);
        lv(6'h27, 6'h20);
        chk({pinOe, mixDriven, mixSum}, {2'b11, 7'h47});
        apb(1, AT, 0);
        cyc(2);
        lv(6'h20, 6'h20);
        apb(1, AT, 32'h18);
        cyc(D_C10 - 10);
        lv(6'h20, 6'h20);
        cyc(20);
        lv(6'h20, 6'h27);
        // All four modes at step 14 of code 1f on both paths
        apb(1, AT, 0);
        apb(1, AR, 32'h1f);
        apb(1, AC, 32'h1f);
        apb(1, AT, 32'hb8);
        cyc(14 * D_1F + 10);
        lv(6'h00, 6'h00);
        chk(pacPin, 0);
        apb(1, AT, 32'hf8);
        cyc(2);
        lv(6'h20, 6'h00);
        chk(pacPin, 0);
        apb(1, AT, 32'h78);
        cyc(2);
        lv(6'h00, 6'h00);
        chk(pacPin, 1);
        apb(1, AT, 32'h38);
        cyc(2);
        lv(6'h1f, 6'h1f);
        // Illegal column code while running in mode 10
        apb(1, AT, 32'hb8);
        apb(1, AC, 32'h02);
        cyc(2);
        lv(6'h20, 6'h20);
        chk({pacPin, mixSum}, {1'b1, 7'h40});
        // Wait keeps running, stop freezes and idles the pins
        apb(1, AC, 32'h1f);
        apb(1, AT, 32'h38);
        apb(1, AP, 32'h1);
        cyc(D_1F + 20);
        lv(6'h27, 6'h27);
        apb(1, AP, 32'h2);
        cyc(3 * D_1F);
        lv(6'h20, 6'h20);
        chk({pinOe, pacPin, mixDriven}, 3'b010);
        // Leaving stop resumes at the frozen step, not three steps on
        apb(1, AP, 32'h0);
        cyc(2);
        lv(6'h27, 6'h27);
        // Scanner runs through entry 27 and wraps to the midpoint
        apb(1, AT, 0);
        apb(1, AT, 32'h38);
        cyc(28 * D_1F - 10);
        lv(6'h19, 6'h19);
        cyc(20);
        lv(6'h20, 6'h20);
        test_done();
    end

    // Watchdog against a hung transfer or wait; tests need about 80k cycles
    initial
    begin
        #1000000;
        fails++;
        test_done();
    end
endmodule
